// >>> core/cpd_deserializer.sv
/*
  Receive side of the coax link: pulse-width demodulation, clock recovery,
  thirteen-bit character shifting, character-received strobe and buffer writes.
  Assumes an external decoder classifies the held character while the strobe
  is high, and a transmitter that owns the line while xmit_active is high.
*/
// Summary of operation
// R01 - Zero is a short high pulse, one a long; sample mid-way after rising edge.
// R02 - Rising level enters an eight-stage delay line advanced at 17 MHz.
// R03 - Delayed edge sets the sample flop, giving one shift pulse per bit.
// R04 - Sample flop active clears the delay line on the next 17 MHz cycle.
// R05 - Edge-arm latch clears with the delay line, blocking repeat samples.
// R06 - Sample flop stays active for exactly one 17 MHz cycle.
// R07 - Start bit at stage twelve raises the strobe; parallel data valid.
// R08 - Strobe masked one cycle before and during each shift pulse.
// R09 - Data characters stretch the strobe by two further 17 MHz cycles.
// R10 - Early tap for twelve bits, late tap once a data character decodes.
// R11 - Sender always sends the thirteenth bit as zero.
// R12 - Transmit-active suppresses edge detection and clock recovery.
// R13 - Poll or Read loads the character to send, then starts transmission.
// R14 - Other characters clear the register when the strobe ends.
// R15 - After Write, the next 1920 data characters go to successive locations.
// R16 - One clock domain, synchronized line, reset clears receive state but sets the edge-arm latch.
`timescale 1ns/100ps
`default_nettype none

module cpd_deserializer
  import cpd_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH_P = FIFO_DEPTH,
  parameter int unsigned BUF_CHARS    = BUFFER_CHARS
)(
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   line_in,
  input  wire logic                   xmit_active,
  input  wire logic                   cmd_data_char,
  input  wire logic                   cmd_poll_read,
  input  wire logic                   cmd_write,
  input  wire logic [CHAR_BITS-1:0]   xmit_char,
  output logic                        char_received,
  output logic [CHAR_BITS-1:0]        char_data,
  output logic                        shift_pulse,
  output logic                        xmit_start,
  output logic                        write_active,
  output logic                        rx_ready,
  output logic                        overrun,
  output logic                        buf_valid,
  input  wire logic                   buf_ready,
  output logic [FIFO_WIDTH-1:0]       buf_data
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic                  sync1;
    logic                  sync2;
    logic [7:0]            tick_acc;
    logic                  tick;
    logic                  arm;
    logic                  gate_prev;
    logic                  sample;
    logic                  late_sel;
    logic [CHAR_BITS-1:0]  sr;
    logic [CHAR_BITS-1:0]  held;
    cpd_phase_t            phase;
    logic [1:0]            stretch;
    logic                  saw_data;
    logic                  saw_poll;
    logic                  saw_write;
    logic [ADDR_BITS-1:0]  wr_left;
    logic [ADDR_BITS-1:0]  wr_addr;
    logic                  start;
    logic                  push;
    logic                  ovr;
  } cpd_rx_st_t;

  cpd_rx_st_t              st_q;
  cpd_rx_st_t              st_d;
  logic [DELAY_STAGES-1:0] taps;
  logic                    tap_sel;
  logic                    gate;
  logic                    dl_clear;
  logic                    dl_din;
  logic                    strobe_raw;
  logic                    mask;
  logic [8:0]              acc_sum;

  cpd_stream_if #(.WIDTH(FIFO_WIDTH)) wr_if ();

  // ************************************************************
  // Delay line and write FIFO
  // ************************************************************
  cpd_edge_delay #(
    .STAGES (DELAY_STAGES)
  ) u_edge_delay_shifter (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tick    (st_q.tick),
    .clear   (dl_clear),
    .din     (dl_din),
    .taps    (taps)
  );

  cpd_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .wr        (wr_if.snk),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  assign wr_if.valid = st_q.push;
  assign wr_if.data  = {st_q.wr_addr, st_q.held};

  // ************************************************************
  // Clock recovery
  // ************************************************************
  assign acc_sum  = {1'b0, st_q.tick_acc} + {1'b0, TICK_STEP};
  // The line level, not a stored edge, feeds the delay line; the arm latch stops a long one re-entering. [R01] [R05]
  assign dl_din   = st_q.sync2 & st_q.arm & ~xmit_active; // [R12]
  // Clearing one tick after the sample flop sets keeps one pulse per bit. [R04]
  assign dl_clear = st_q.sample | xmit_active; // [R12]
  assign tap_sel  = st_q.late_sel ? taps[LATE_TAP-1] : taps[EARLY_TAP-1]; // [R10]
  // One-cycle gate: only a fresh rise of the tap may set the sample flop. [R06]
  assign gate     = tap_sel & ~st_q.gate_prev & ~st_q.sample & ~xmit_active;
  assign mask       = gate | st_q.sample; // [R08]
  assign strobe_raw = st_q.sr[START_STAGE-1] & ~mask; // [R07]

  assign char_received = (st_q.phase == PH_STROBE) | (st_q.phase == PH_STRETCH);
  assign char_data     = st_q.held;
  assign shift_pulse   = st_q.sample; // [R03]
  assign xmit_start    = st_q.start;
  assign write_active  = (st_q.wr_left != '0);
  assign rx_ready      = wr_if.ready;
  assign overrun       = st_q.ovr;

  always_comb
  begin
    st_d       = st_q;
    st_d.sync1 = line_in; // [R16]
    st_d.sync2 = st_q.sync1;
    st_d.start = 1'b0;
    st_d.push  = st_q.push & ~wr_if.ready;
    st_d.ovr   = 1'b0;

    // Fractional divider: 17 ticks in every 200 cycles, spacing 11 or 12 cycles. [R02]
    if (acc_sum >= {1'b0, TICK_WRAP})
    begin
      st_d.tick_acc = 8'(acc_sum - {1'b0, TICK_WRAP});
      st_d.tick     = 1'b1;
    end
    else
    begin
      st_d.tick_acc = acc_sum[7:0];
      st_d.tick     = 1'b0;
    end

    if (st_q.tick)
    begin
      st_d.gate_prev = tap_sel;
      // The flop lives one tick, then the line is cleared behind it. [R03] [R06]
      st_d.sample    = gate;
      if (dl_clear)
        st_d.arm = 1'b0; // [R05]
      else if (!st_q.sync2)
        st_d.arm = 1'b1;
      // Data is shifted while the line is still high for a one, low for a zero. [R01] [R03]
      if (st_q.sample)
        st_d.sr = {st_q.sr[CHAR_BITS-2:0], st_q.sync2};
    end

    // ************************************************************
    // Strobe sequencing
    // ************************************************************
    unique case (st_q.phase)
      PH_SHIFT:
      begin
        if (strobe_raw)
        begin
          st_d.phase     = PH_STROBE; // [R07]
          st_d.held      = st_q.sr;
          st_d.saw_data  = 1'b0;
          st_d.saw_poll  = 1'b0;
          st_d.saw_write = 1'b0;
        end
      end
      PH_STROBE:
      begin
        st_d.saw_data  = st_q.saw_data | cmd_data_char;
        st_d.saw_poll  = st_q.saw_poll | cmd_poll_read;
        st_d.saw_write = st_q.saw_write | cmd_write;
        if (cmd_data_char)
          st_d.late_sel = 1'b1; // [R10]
        if (!strobe_raw)
        begin
          if (st_q.saw_data)
          begin
            st_d.phase   = PH_STRETCH; // [R09]
            st_d.stretch = STRETCH_TICKS;
            if (write_active)
            begin
              // A full FIFO drops the character and reports it; the line cannot be stalled. [R15]
              st_d.push = wr_if.ready;
              st_d.ovr  = ~wr_if.ready;
            end
          end
          else
            st_d.phase = PH_FINISH;
        end
      end
      PH_STRETCH:
      begin
        if (st_q.tick)
        begin
          if (st_q.stretch == 2'h1)
            st_d.phase = PH_FINISH; // [R09]
          st_d.stretch = st_q.stretch - 2'h1;
        end
      end
      PH_FINISH:
      begin
        st_d.phase    = PH_SHIFT;
        st_d.late_sel = 1'b0;
        if (st_q.saw_poll)
        begin
          st_d.sr    = xmit_char; // [R13]
          st_d.start = 1'b1;
        end
        else
          st_d.sr = '0; // [R14]
        if (st_q.saw_write)
        begin
          st_d.wr_left = ADDR_BITS'(BUF_CHARS); // [R15]
          st_d.wr_addr = '0;
        end
      end
    endcase

    // Count drops once per character offered, written or dropped; address advances only per character written. [R15]
    if ((st_q.phase == PH_STROBE) && !strobe_raw && st_q.saw_data && write_active)
    begin
      st_d.wr_left = st_q.wr_left - 1'b1;
    end
    if (st_q.push && wr_if.ready)
      st_d.wr_addr = st_q.wr_addr + 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q       <= '0; // [R16]
      st_q.arm   <= 1'b1;
      st_q.phase <= PH_SHIFT;
    end
    else
      st_q <= st_d;
  end

endmodule // cpd_deserializer

`default_nettype wire

// >>> core/cpd_edge_delay.sv
/*
  Tapped delay shift register that carries a line level forward at the 17 MHz rate.
  Assumes the caller supplies the 17 MHz tick and the clear.
*/
`timescale 1ns/100ps
`default_nettype none

module cpd_edge_delay
  import cpd_pkg::*;
#(
  parameter int unsigned STAGES = DELAY_STAGES
)(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              tick,
  input  wire logic              clear,
  input  wire logic              din,
  output logic [STAGES-1:0]      taps
);
  typedef struct packed {
    logic [STAGES-1:0] stages;
  } cpd_delay_st_t;

  cpd_delay_st_t st_q;
  cpd_delay_st_t st_d;

  assign taps = st_q.stages;

  always_comb
  begin
    st_d = st_q;
    if (tick)
    begin
      if (clear)
        st_d.stages = '0;
      else
        st_d.stages = {st_q.stages[STAGES-2:0], din};
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end
endmodule // cpd_edge_delay

`default_nettype wire

// >>> core/cpd_fifo.sv
/*
  Synchronous FIFO holding received data characters with their buffer address.
  Assumes one clock; full and empty are exact.
*/
`timescale 1ns/100ps
`default_nettype none

module cpd_fifo
  import cpd_pkg::*;
#(
  parameter int unsigned WIDTH = FIFO_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  cpd_stream_if.snk             wr,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } cpd_fifo_st_t;

  cpd_fifo_st_t     st_q;
  cpd_fifo_st_t     st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign wr.ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data  = mem[st_q.rp];
  assign push      = wr.valid & wr.ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    st_d = st_q;
    if (push)
      st_d.wp = st_q.wp + 1'b1;
    if (pop)
      st_d.rp = st_q.rp + 1'b1;
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Storage has no reset; the counters alone decide what is valid.
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[st_q.wp] <= wr.data;
  end
endmodule // cpd_fifo

`default_nettype wire

// >>> core/cpd_pkg.sv
/*
  Shared constants and types for the coax pulse-width character deserializer.
  Assumes a single 200 MHz clock from which the 17 MHz logic rate is derived.
*/
package cpd_pkg;

  // ************************************************************
  // Clocking
  // ************************************************************
  localparam int unsigned MCLK_MHZ      = 200;
  localparam int unsigned LOGIC_CLK_MHZ = 17;
  localparam logic [7:0]  TICK_STEP     = 8'(LOGIC_CLK_MHZ);
  localparam logic [7:0]  TICK_WRAP     = 8'(MCLK_MHZ);

  // ************************************************************
  // Line timing, nominal
  // ************************************************************
  localparam int unsigned ZERO_PULSE_NS = 210;
  localparam int unsigned ONE_PULSE_NS  = 630;
  localparam int unsigned SAMPLE_NS     = 420;

  // ************************************************************
  // Delay line and character register
  // ************************************************************
  localparam int unsigned DELAY_STAGES  = 8;
  localparam int unsigned EARLY_TAP     = 6;
  localparam int unsigned LATE_TAP      = 8;
  localparam int unsigned CHAR_BITS     = 13;
  localparam int unsigned START_STAGE   = 12;
  localparam logic [1:0]  STRETCH_TICKS = 2'h2;

  // ************************************************************
  // Buffer writing
  // ************************************************************
  localparam int unsigned BUFFER_CHARS  = 1920;
  localparam int unsigned ADDR_BITS     = 11;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned FIFO_WIDTH    = ADDR_BITS + CHAR_BITS;

  typedef enum logic [1:0] {
    PH_SHIFT   = 2'b00,
    PH_STROBE  = 2'b01,
    PH_STRETCH = 2'b10,
    PH_FINISH  = 2'b11
  } cpd_phase_t;

endpackage

// >>> core/cpd_stream_if.sv
/*
  Valid/ready stream carrier between the deserializer and its write FIFO.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface cpd_stream_if #(
  parameter int unsigned WIDTH = 24
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // cpd_stream_if

`default_nettype wire

// >>> test/cpd_deserializer_asserts.sv
/* Port checks for the deserializer, bound into it.
   Assumes one mclk domain and the active-low async reset_n. */
`timescale 1ns/100ps
`default_nettype none
module cpd_deserializer_asserts
  import cpd_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH_P = FIFO_DEPTH,
  parameter int unsigned BUF_CHARS    = BUFFER_CHARS
)(
  input wire logic                  mclk,
  input wire logic                  reset_n,
  input wire logic                  line_in,
  input wire logic                  xmit_active,
  input wire logic                  cmd_data_char,
  input wire logic                  cmd_poll_read,
  input wire logic                  cmd_write,
  input wire logic [CHAR_BITS-1:0]  xmit_char,
  input wire logic                  char_received,
  input wire logic [CHAR_BITS-1:0]  char_data,
  input wire logic                  shift_pulse,
  input wire logic                  xmit_start,
  input wire logic                  write_active,
  input wire logic                  rx_ready,
  input wire logic                  overrun,
  input wire logic                  buf_valid,
  input wire logic                  buf_ready,
  input wire logic [FIFO_WIDTH-1:0] buf_data
);
  // ********
  // Helpers
  // ********
  // The gap count starts saturated so the first pulse after reset is not judged.
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [5:0] xa_q;
  logic       pr_q;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hi_q <= 8'h00;
      lo_q <= 8'hff;
      xa_q <= 6'h00;
      pr_q <= 1'b0;
    end
    else
    begin
      hi_q <= shift_pulse ? hi_q + 8'h01 : 8'h00;
      lo_q <= shift_pulse ? 8'h00 : (lo_q == 8'hff ? lo_q : lo_q + 8'h01);
      xa_q <= !xmit_active ? 6'h00 : (xa_q == 6'h3f ? xa_q : xa_q + 6'h01);
      pr_q <= char_received & (pr_q | cmd_poll_read);
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ********
  // Checks
  // ********
  property p_width;
    $fell(shift_pulse) |-> (hi_q == 8'h0b || hi_q == 8'h0c);
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_gap;
    $rose(shift_pulse) |-> lo_q > 8'h64;
  endproperty
  a_gap: assert property (p_gap) else $error("repeat pulse");
  property p_quiet;
    xa_q == 6'h3f |-> !shift_pulse;
  endproperty
  a_quiet: assert property (p_quiet) else $error("rx in tx");
  property p_mask;
    $rose(char_received) |-> !shift_pulse;
  endproperty
  a_mask: assert property (p_mask) else $error("strobe on pulse");
  property p_hold;
    char_received && $past(char_received) |-> $stable(char_data);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_start;
    $rose(char_received) |-> char_data[START_STAGE-1];
  endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_poll;
    $fell(char_received) && pr_q |-> ##[0:3] xmit_start;
  endproperty
  a_poll: assert property (p_poll) else $error("no tx start");
  property p_ovr;
    overrun |-> $past(rx_ready) == 1'b0;
  endproperty
  a_ovr: assert property (p_ovr) else $error("bad overrun");
endmodule // cpd_deserializer_asserts
bind cpd_deserializer cpd_deserializer_asserts #(.FIFO_DEPTH_P(FIFO_DEPTH_P), .BUF_CHARS(BUF_CHARS)) u_chk (
  .mclk(mclk), .reset_n(reset_n), .line_in(line_in), .xmit_active(xmit_active), .cmd_data_char(cmd_data_char),
  .cmd_poll_read(cmd_poll_read), .cmd_write(cmd_write), .xmit_char(xmit_char), .char_received(char_received),
  .char_data(char_data), .shift_pulse(shift_pulse), .xmit_start(xmit_start), .write_active(write_active),
  .rx_ready(rx_ready), .overrun(overrun), .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_data(buf_data));
`default_nettype wire

// >>> test/cpd_deserializer_tb.sv
/* Self-checking bench for the deserializer with a line sender model.
   Assumes the package constants and a 200 MHz mclk. */
`timescale 1ns/100ps
`default_nettype none
module cpd_deserializer_tb
  import cpd_pkg::*;
;
  localparam int DEPTH = 4;
  localparam int WCHARS = 6;
  logic                  mclk;
  logic                  reset_n = 1'b0;
  logic                  line_in;
  logic                  xmit_active = 1'b0;
  logic                  cmd_data_char = 1'b0;
  logic                  cmd_poll_read = 1'b0;
  logic                  cmd_write = 1'b0;
  logic                  buf_ready = 1'b0;
  logic                  go = 1'b0;
  logic                  busy;
  logic [10:0]           payload = 11'h000;
  logic                  char_received, shift_pulse, xmit_start, write_active, rx_ready, overrun, buf_valid;
  logic [CHAR_BITS-1:0]  char_data, got;
  logic [FIFO_WIDTH-1:0] buf_data;
  logic                  ln_q, sp_q, cr_q;
  int nsp, since, gap, lat, lat1, len, at_strobe, nxs, novr, kind, ctrl_len, ctrl_gap, cyc;
  int failures = 0;
  int comparisons = 0;
  cpd_deserializer #(.FIFO_DEPTH_P(DEPTH), .BUF_CHARS(WCHARS)) DUT (
    .mclk(mclk), .reset_n(reset_n), .line_in(line_in), .xmit_active(xmit_active), .cmd_data_char(cmd_data_char),
    .cmd_poll_read(cmd_poll_read), .cmd_write(cmd_write), .xmit_char(13'h0a5a), .char_received(char_received),
    .char_data(char_data), .shift_pulse(shift_pulse), .xmit_start(xmit_start), .write_active(write_active),
    .rx_ready(rx_ready), .overrun(overrun), .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_data(buf_data));
  cpd_line_model u_sender (.mclk(mclk), .reset_n(reset_n), .go(go), .payload(payload), .line(line_in), .busy(busy));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ********
  // Decoder stand-in and monitor
  // ********
  always @(negedge mclk)
  begin
    cmd_data_char <= char_received && kind == 1;
    cmd_poll_read <= char_received && kind == 2;
    cmd_write <= char_received && kind == 3;
    lat = (line_in && !ln_q) ? 0 : lat + 1;
    since++;
    if (shift_pulse && !sp_q)
    begin
      nsp++;
      gap = since;
      since = 0;
      if (nsp == 1)
        lat1 = lat;
    end
    if (char_received && !cr_q)
    begin
      got = char_data;
      at_strobe = nsp;
      len = 0;
    end
    len += char_received;
    nxs += xmit_start;
    novr += overrun;
    ln_q = line_in;
    sp_q = shift_pulse;
    cr_q = char_received;
  end
  always @(negedge mclk)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      failures++;
      summarize();
    end
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic summarize;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send_char(input int k, input logic [10:0] p);
    @(negedge mclk);
    kind = k;
    payload = p;
    nsp = 0;
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    while (busy)
      @(negedge mclk);
  endtask
  task automatic t_reset;
    chk(char_received === 1'b0 && shift_pulse === 1'b0 && xmit_start === 1'b0, "reset strobe");
    chk(buf_valid === 1'b0 && rx_ready === 1'b1 && write_active === 1'b0 && overrun === 1'b0, "reset fifo");
  endtask
  task automatic t_ctrl;
    logic [10:0] tbl [3];
    tbl = '{11'h7ff, 11'h2a5, 11'h001};
    foreach (tbl[i])
    begin
      send_char(0, tbl[i]);
      chk(got === {2'b01, tbl[i]}, "control bits");
      chk(at_strobe == 12 && nsp == 13, "pulse count");
      chk(lat1 inside {[68:90]}, "sample delay");
    end
    ctrl_len = len;
    ctrl_gap = gap;
  endtask
  task automatic t_data;
    send_char(1, 11'h555);
    chk(got === {2'b01, 11'h555}, "data bits");
    chk((gap - ctrl_gap) inside {[22:25]}, "late tap");
    chk((len - ctrl_len - gap + ctrl_gap) inside {[22:25]}, "stretch");
  endtask
  task automatic t_write;
    send_char(3, 11'h0f0);
    chk(write_active === 1'b1, "window open");
    for (int i = 0; i < WCHARS; i++)
      send_char(1, 11'h100 + 11'(i));
    chk(write_active === 1'b0 && rx_ready === 1'b0 && novr == WCHARS - DEPTH, "window end");
    for (int i = 0; i < DEPTH; i++)
    begin
      @(negedge mclk);
      chk(buf_valid === 1'b1 && buf_data === {11'(i), 2'b01, 11'h100 + 11'(i)}, "buffer word");
      buf_ready = 1'b1;
    end
    @(negedge mclk);
    buf_ready = 1'b0;
    chk(buf_valid === 1'b0, "drained");
  endtask
  task automatic t_poll;
    chk(nxs == 0, "early tx start");
    send_char(2, 11'h3c3);
    chk(nxs == 1, "poll tx start");
  endtask
  task automatic t_quiet;
    xmit_active = 1'b1;
    repeat (80) @(negedge mclk);
    send_char(0, 11'h7ff);
    chk(nsp == 0, "rx in tx");
    xmit_active = 1'b0;
  endtask
  initial
  begin
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    t_reset();
    t_ctrl();
    t_data();
    t_write();
    t_poll();
    t_quiet();
    summarize();
  end
endmodule // cpd_deserializer_tb
`default_nettype wire

// >>> test/cpd_line_model.sv
/* Sender on the coax line: one framed character per go request.
   Assumes it shares reset with the receiver so bit frames align to its tick. */
`timescale 1ns/100ps
`default_nettype none
module cpd_line_model
  import cpd_pkg::*;
#(
  parameter int unsigned BIT_CY = 200
)(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        go,
  input wire logic [10:0] payload,
  output logic            line,
  output logic            busy
);
  // A frame of 200 cycles is 17 ticks, so every character sees the same tick phase.
  int unsigned ph;
  logic [12:0] word;
  always @(negedge mclk or negedge reset_n)
    ph <= (!reset_n || ph == BIT_CY - 1) ? 0 : ph + 1;
  initial
  begin
    line = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge mclk iff go);
      busy = 1'b1;
      word = {1'b1, payload, 1'b0};
      @(negedge mclk);
      while (ph != 0)
        @(negedge mclk);
      for (int i = 12; i >= 0; i--)
      begin
        line = 1'b1;
        repeat ((word[i] ? ONE_PULSE_NS : ZERO_PULSE_NS) / 5) @(negedge mclk);
        line = 1'b0;
        repeat (BIT_CY - (word[i] ? ONE_PULSE_NS : ZERO_PULSE_NS) / 5) @(negedge mclk);
      end
      repeat (BIT_CY) @(negedge mclk);
      busy = 1'b0;
    end
  end
endmodule // cpd_line_model
`default_nettype wire
